/* include/cic_defs.svh */
// What this block does
// RQ1: Filter passes level after N valid samples
// RQ2: Code 0000 means unfiltered system clock sampling
// RQ3: Codes 1-3 use input clock, N 2/4/8
// RQ4: Codes 4-9 use dead-time clock /2/4/8, N 6/8
// RQ5: Codes 10-15 use /16 or /32, N 5/6/8
// RQ6: Prescaler passes every 1, 2, 4, 8 events
// RQ7: Disabled channel clears its prescaler count
// RQ8: Select 00 makes channel an output
// RQ9: Channels 0/1: 01 own, 10 partner input
// RQ10: Channels 2/3: 01 own, 10 partner input
// RQ11: Select 11 routes trigger edge signal
// RQ12: Select field writable only while channel disabled
// RQ13: Filter 3:0, select 17:16, prescale 19:18
// RQ14: Channel 0 may use XOR of three pins
// RQ15: Agreeing sample restarts filter count
// RQ16: Reserved bits read zero, ignore writes
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH
`define CIC_OFS_CHAN0_CFG   8'h20
`define CIC_OFS_CHAN1_CFG   8'h24
`define CIC_OFS_CHAN2_CFG   8'h28
`define CIC_OFS_CHAN3_CFG   8'h2c
`define CIC_OFS_CHAN_ENABLE 8'h30
`define CIC_OFS_STATUS      8'h34
`define CIC_FILT_LSB        0
`define CIC_SEL_LSB         16
`define CIC_PSC_LSB         18
`define CIC_XOR_BIT         31
`define CIC_CFG_MASK        32'h000f_000f
`define CIC_CFG_MASK_CH0    32'h800f_000f
`define CIC_CFG_RESET       32'h0000_0000
`endif

/* include/cic_pkg.sv */
package cic_pkg;
    typedef logic [3:0] cic_filter_type;
    typedef enum logic [1:0] {CIC_SEL_OUTPUT, CIC_SEL_OWN, CIC_SEL_PARTNER, CIC_SEL_TRIGGER} cic_select_type;
    typedef enum logic [0:0] {CIC_ST_IDLE, CIC_ST_RUN} cic_ready_type;
endpackage : cic_pkg

/* hdl/cic_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cic_defs.svh"
// One channel's digital filter: sample tick selection, N-agreement counter.
module cic_filter
    import cic_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic           raw_in,
    input  wire logic           clkin_tick,
    input  wire logic [5:0]     dts_tick,
    input  wire cic_filter_type setting,
    output logic                filtered
);
    typedef struct packed {
        logic       level;
        logic [3:0] count;
    } cic_filt_state_type;

    cic_filt_state_type state;
    cic_filt_state_type next_state;
    logic               tick;
    logic [3:0]         need;

    // ------------------------------------------------------------
    // Sample rate and N per code
    // ------------------------------------------------------------
    always_comb begin
        tick = 1'b0;
        need = 4'h1;
        case (setting)
            4'h0: begin tick = 1'b1;        need = 4'h1; end // RQ2
            4'h1: begin tick = clkin_tick;  need = 4'h2; end // RQ3
            4'h2: begin tick = clkin_tick;  need = 4'h4; end // RQ3
            4'h3: begin tick = clkin_tick;  need = 4'h8; end // RQ3
            4'h4: begin tick = dts_tick[1]; need = 4'h6; end // RQ4
            4'h5: begin tick = dts_tick[1]; need = 4'h8; end // RQ4
            4'h6: begin tick = dts_tick[2]; need = 4'h6; end // RQ4
            4'h7: begin tick = dts_tick[2]; need = 4'h8; end // RQ4
            4'h8: begin tick = dts_tick[3]; need = 4'h6; end // RQ4
            4'h9: begin tick = dts_tick[3]; need = 4'h8; end // RQ4
            4'ha: begin tick = dts_tick[4]; need = 4'h5; end // RQ5
            4'hb: begin tick = dts_tick[4]; need = 4'h6; end // RQ5
            4'hc: begin tick = dts_tick[4]; need = 4'h8; end // RQ5
            4'hd: begin tick = dts_tick[5]; need = 4'h5; end // RQ5
            4'he: begin tick = dts_tick[5]; need = 4'h6; end // RQ5
            default: begin tick = dts_tick[5]; need = 4'h8; end // RQ5
        endcase
    end

    always_comb begin
        next_state = state;
        if (tick) begin
            if (raw_in == state.level) begin
                next_state.count = 4'h0; // RQ15
            end else if (state.count + 4'h1 >= need) begin
                next_state.level = raw_in; // RQ1
                next_state.count = 4'h0;
            end else begin
                next_state.count = state.count + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign filtered = state.level;
endmodule : cic_filter
`default_nettype wire

/* hdl/cic_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cic_defs.svh"
module cic_top
    import cic_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    input  wire logic [3:0]  channel_pin,
    input  wire logic        timer_input_clock_tick,
    input  wire logic        dead_time_sample_clock_tick,
    input  wire logic        trigger_edge_signal,
    output logic [3:0]       capture_event,
    output logic [3:0]       channel_is_output,
    output logic [3:0]       channel_filtered
);
    typedef struct packed {
        logic [3:0][31:0] cfg;
        logic [3:0]       enable;
        logic [3:0][2:0]  psc_count;
        logic [3:0]       prev_sel;
        logic [3:0]       capture;
        logic [4:0]       dts_div;
        logic [5:0]       dts_tick;
        logic [31:0]      rdata;
    } cic_state_type;

    cic_state_type state;
    cic_state_type next_state;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ofs_cfg0   = `CIC_OFS_CHAN0_CFG;
    localparam logic [7:0] ofs_cfg1   = `CIC_OFS_CHAN1_CFG;
    localparam logic [7:0] ofs_cfg2   = `CIC_OFS_CHAN2_CFG;
    localparam logic [7:0] ofs_cfg3   = `CIC_OFS_CHAN3_CFG;
    localparam logic [7:0] ofs_enable = `CIC_OFS_CHAN_ENABLE;
    localparam logic [7:0] ofs_status = `CIC_OFS_STATUS;

    // ------------------------------------------------------------
    // Per-channel nets
    // ------------------------------------------------------------
    // Nets, so each pass of the channel loop drives its own bit
    wire logic [3:0]       raw_in;
    wire logic [3:0]       filt_out;
    wire logic [3:0][3:0]  filt_field;
    wire logic [3:0][1:0]  sel_field;
    wire logic [3:0][1:0]  psc_field;

    wire logic [3:0]       sel_in;
    wire logic [3:0]       sel_rise;

    wire logic [3:0]       cfg_hit;
    wire logic [3:0][31:0] cfg_mask;
    wire logic [3:0][31:0] cfg_next;

    wire logic [3:0][2:0]  psc_limit;
    wire logic [3:0]       psc_wrap;
    wire logic [3:0][2:0]  psc_next;
    wire logic [3:0]       capture_next;

    wire logic [5:1]       dts_fire;

    logic                  chan0_raw;
    logic                  enable_hit;
    logic [31:0]           read_word;

    // ------------------------------------------------------------
    // Channel 0 source
    // ------------------------------------------------------------
    // Three-pin XOR lets one channel see any edge of a hall-type trio
    assign chan0_raw = state.cfg[0][`CIC_XOR_BIT] ?
                       (channel_pin[0] ^ channel_pin[1] ^ channel_pin[2]) : channel_pin[0]; // RQ14

    // ------------------------------------------------------------
    // Dead-time tick dividers
    // ------------------------------------------------------------
    genvar gi;
    genvar gk;

    generate
        for (gk = 1; gk < 6; gk++) begin : g_dts
            // Stage k fires once every 2**k dead-time ticks
            assign dts_fire[gk] = dead_time_sample_clock_tick && (state.dts_div[gk - 1:0] == {gk{1'b1}});
        end
    endgenerate

    // ------------------------------------------------------------
    // Per-channel filter, source select, write mask, prescaler
    // ------------------------------------------------------------
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            logic        sel_pick;
            logic [31:0] mask_pick;
            logic [2:0]  psc_pick;
            logic        capture_pick;

            assign raw_in[gi] = (gi == 0) ? chan0_raw : channel_pin[gi];

            cic_filter u_filter (
                .ref_clk    (ref_clk),
                .rst_n      (rst_n),
                .raw_in     (raw_in[gi]),
                .clkin_tick (timer_input_clock_tick),
                .dts_tick   (state.dts_tick),
                .setting    (filt_field[gi]),
                .filtered   (filt_out[gi])
            );

            assign filt_field[gi] = state.cfg[gi][`CIC_FILT_LSB +: 4]; // RQ13
            assign sel_field[gi]  = state.cfg[gi][`CIC_SEL_LSB +: 2];  // RQ13
            assign psc_field[gi]  = state.cfg[gi][`CIC_PSC_LSB +: 2];  // RQ13

            // Source mux; pairs are 0/1 and 2/3, so the partner is gi xor 1
            always_comb begin
                case (cic_select_type'(sel_field[gi]))
                    CIC_SEL_OWN: begin
                        sel_pick = filt_out[gi]; // RQ9 RQ10
                    end
                    CIC_SEL_PARTNER: begin
                        sel_pick = filt_out[gi ^ 1]; // RQ9 RQ10
                    end
                    CIC_SEL_TRIGGER: begin
                        sel_pick = trigger_edge_signal; // RQ11
                    end
                    default: begin
                        sel_pick = 1'b0; // RQ8
                    end
                endcase
            end
            assign sel_in[gi]   = sel_pick;
            assign sel_rise[gi] = sel_pick & ~state.prev_sel[gi];

            // Select bits open only while the channel is disabled
            assign cfg_hit[gi] = reg_write && (reg_addr == 8'(`CIC_OFS_CHAN0_CFG + 4 * gi));
            always_comb begin
                mask_pick = (gi == 0) ? `CIC_CFG_MASK_CH0 : `CIC_CFG_MASK; // RQ16
                mask_pick[`CIC_SEL_LSB +: 2] = 2'h0;
                if (!state.enable[gi]) begin
                    mask_pick[`CIC_SEL_LSB +: 2] = 2'h3; // RQ12
                end
            end
            assign cfg_mask[gi] = mask_pick;
            assign cfg_next[gi] = cfg_hit[gi] ? ((state.cfg[gi] & ~mask_pick) | (reg_wdata & mask_pick))
                                              : state.cfg[gi];

            // Count wraps at 2**code - 1, so code 00 passes every edge
            assign psc_limit[gi] = 3'((4'h1 << psc_field[gi]) - 4'h1);
            assign psc_wrap[gi]  = state.psc_count[gi] >= psc_limit[gi];
            always_comb begin
                psc_pick     = state.psc_count[gi];
                capture_pick = 1'b0;
                if (!state.enable[gi]) begin
                    psc_pick = 3'h0; // RQ7
                end else if (sel_rise[gi]) begin
                    if (psc_wrap[gi]) begin
                        psc_pick     = 3'h0;
                        capture_pick = sel_field[gi] != 2'h0; // RQ6
                    end else begin
                        psc_pick = state.psc_count[gi] + 3'h1; // RQ6
                    end
                end
            end
            assign psc_next[gi]     = psc_pick;
            assign capture_next[gi] = capture_pick;
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Enable word stands in for the channel control enable bits
    assign enable_hit = reg_write && (reg_addr == ofs_enable);

    always_comb begin
        next_state = state;

        // Divided ticks are registered, one cycle behind the raw tick
        next_state.dts_tick = {dts_fire, dead_time_sample_clock_tick};
        if (dead_time_sample_clock_tick) begin
            next_state.dts_div = state.dts_div + 5'h1;
        end

        // Per-channel registers
        for (int c = 0; c < 4; c++) begin
            next_state.cfg[c]       = cfg_next[c];
            next_state.prev_sel[c]  = sel_in[c];
            next_state.psc_count[c] = psc_next[c];
            next_state.capture[c]   = capture_next[c];
        end

        if (enable_hit) begin
            next_state.enable = reg_wdata[3:0];
        end

        // Read data stand for one cycle only, zero otherwise
        next_state.rdata = '0;
        if (reg_read) begin
            next_state.rdata = read_word;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        read_word = '0;
        case (reg_addr)
            ofs_cfg0: begin
                read_word = state.cfg[0];
            end
            ofs_cfg1: begin
                read_word = state.cfg[1];
            end
            ofs_cfg2: begin
                read_word = state.cfg[2];
            end
            ofs_cfg3: begin
                read_word = state.cfg[3];
            end
            ofs_enable: begin
                read_word = {28'h0, state.enable};
            end
            ofs_status: begin
                read_word = {28'h0, filt_out};
            end
            default: begin
                read_word = '0; // RQ16
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata        = state.rdata;
    assign capture_event    = state.capture;
    assign channel_filtered = filt_out;

    // Decoded straight from the register, no extra delay
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            channel_is_output[c] = sel_field[c] == 2'h0; // RQ8
        end
    end
endmodule : cic_top
`default_nettype wire

/* sim/cic_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Capture pins and free-running sample ticks
// ----------------------------------------
module cic_pins_model
    import cic_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] pin_drive,
    output logic [3:0]      channel_pin,
    output logic            clkin_tick,
    output logic            dts_tick
);
    logic [1:0] phase;
    // Ticks never stop, so a pin change lands at an arbitrary sample phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) phase <= 2'h0;
        else phase <= phase + 2'h1;
    end
    assign clkin_tick  = (phase == 2'h3);
    assign dts_tick    = phase[0];
    assign channel_pin = pin_drive;
endmodule : cic_pins_model
`default_nettype wire

/* sim/cic_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cic_top_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0]  channel_pin,
    input wire logic [3:0]  capture_event,
    input wire logic [3:0]  channel_is_output,
    input wire logic [3:0]  channel_filtered
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // Port relations
    // ----------------
    chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("rdata not idle");
    chk_cfg_reserved: assert property ($past(reg_read) && $past(reg_addr) inside {8'h24, 8'h28, 8'h2c}
        |-> (reg_rdata & ~32'h000f_000f) == 32'h0) else $error("reserved bits read set");
    chk_unmapped_zero: assert property ($past(reg_read) && $past(reg_addr) == 8'h3c |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_out_decode: assert property ($past(reg_read) && $past(reg_addr) == 8'h24
        |-> channel_is_output[1] == (reg_rdata[17:16] == 2'b00)) else $error("output flag wrong");
    chk_out_no_event: assert property ((capture_event & $past(channel_is_output)) == 4'h0)
        else $error("event on output channel");
    chk_event_pulse: assert property (|capture_event |=> (capture_event & $past(capture_event)) == 4'h0)
        else $error("event longer than one cycle");
    chk_out_stable: assert property (!$past(reg_write) |-> $stable(channel_is_output))
        else $error("output flag moved without write");
    chk_filt_follow: assert property ($changed(channel_filtered[1])
        |-> channel_filtered[1] == $past(channel_pin[1])) else $error("filter moved to wrong level");
endmodule : cic_top_asserts
bind cic_top cic_top_asserts i_cic_top_asserts (.ref_clk, .rst_n, .reg_addr, .reg_write, .reg_read, .reg_rdata,
    .channel_pin, .capture_event, .channel_is_output, .channel_filtered);
`default_nettype wire

/* sim/capture_input_conditioning_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t %h %h", $time, g, e); end end
module capture_input_conditioning_test
    import cic_pkg::*;
;
    logic        ref_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, trig = 1'b0, clkin_tick, dts_tick;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hb12e, d, q;
    logic [3:0]  pins = 4'h0, channel_pin, capture_event, channel_is_output, channel_filtered;
    int          errors = 0, n_checks = 0, ev_cnt, lat, ch, sel, psc, src;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (capture_event[ch] === 1'b1) ev_cnt++;
    cic_pins_model i_cic_pins_model (.ref_clk, .rst_n, .pin_drive(pins), .channel_pin, .clkin_tick, .dts_tick);
    cic_top i_cic_top (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .channel_pin,
        .timer_input_clock_tick(clkin_tick), .dead_time_sample_clock_tick(dts_tick), .trigger_edge_signal(trig),
        .capture_event, .channel_is_output, .channel_filtered);
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int fper(input int c);
        if (c < 4) return 4;
        if (c < 10) return 2 << ((c - 2) / 2);
        return c < 13 ? 32 : 64;
    endfunction : fper
    function automatic int fcnt(input int c);
        if (c < 4) return 1 << c;
        if (c < 10) return c[0] ? 8 : 6;
        return c % 3 == 1 ? 5 : (c % 3 == 2 ? 6 : 8);
    endfunction : fcnt
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge ref_clk) reg_write <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk) reg_read <= 1'b0;
        @(negedge ref_clk) v = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    // Index 4 stands for the trigger edge line
    task automatic edges(input int n, input int p);
        repeat (n) begin
            if (p == 4) trig <= 1'b1; else pins[p] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            if (p == 4) trig <= 1'b0; else pins[p] <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
    endtask : edges
    task automatic end_of_test();
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 1; i < 4; i++) begin
            rd(8'h20 + 8'(4 * i), q);
            `CHK(q, 32'h0)
        end
        repeat (24) begin
            ch = 1 + rnd() % 3;
            d = rnd();
            wr(8'h20 + 8'(4 * ch), d);
            rd(8'h20 + 8'(4 * ch), q);
            `CHK(q, d & 32'h000f_000f)
            `CHK(channel_is_output[ch], d[17:16] == 2'b00)
            wr(8'h30, 32'h1 << ch);
            wr(8'h20 + 8'(4 * ch), d ^ 32'h0003_0001);
            rd(8'h20 + 8'(4 * ch), q);
            `CHK(q, (d ^ 32'h1) & 32'h000f_000f)
            wr(8'h30, 32'h0);
        end
        for (int c = 0; c < 16; c++) begin
            wr(8'h24, 32'(c));
            pins[1] <= ~pins[1];
            lat = 0;
            do begin
                @(posedge ref_clk);
                lat++;
                @(negedge ref_clk);
            end while (channel_filtered[1] !== pins[1] && lat < 600);
            if (c == 0) `CHK(lat, 1)
            else `CHK(lat > (fcnt(c) - 1) * fper(c) && lat <= fcnt(c) * fper(c) + 4, 1'b1)
            if (lat >= 600) end_of_test();
            @(posedge ref_clk);
        end
        // Short disagreeing runs split by agreement must never reach the count
        wr(8'h24, 32'h3);
        repeat (2) begin
            pins[1] <= ~pins[1];
            repeat (20) @(posedge ref_clk);
            pins[1] <= ~pins[1];
            repeat (8) @(posedge ref_clk);
        end
        @(negedge ref_clk) `CHK(channel_filtered[1], pins[1])
        @(posedge ref_clk);
        pins <= 4'h0;
        for (int i = 0; i < 4; i++) wr(8'h20 + 8'(4 * i), 32'h0);
        for (int k = 0; k < 48; k++) begin
            ch = k / 12;
            sel = 1 + (k % 12) / 4;
            psc = k % 4;
            src = sel == 3 ? 4 : (sel == 2 ? ch ^ 1 : (ch == 0 ? 2 : ch));
            wr(8'h30, 32'h0);
            wr(8'h20 + 8'(4 * ch), {1'b1, 11'h0, 2'(psc), 2'(sel), 16'h0});
            wr(8'h30, 32'h1 << ch);
            edges(3, src);
            wr(8'h30, 32'h0);
            wr(8'h30, 32'h1 << ch);
            @(negedge ref_clk) ev_cnt = 0;
            @(posedge ref_clk);
            edges(7, src);
            `CHK(ev_cnt, 7 >> psc)
        end
        rd(8'h3c, q);
        `CHK(q, 32'h0)
        end_of_test();
    end
endmodule : capture_input_conditioning_test
`default_nettype wire
